// *** rtl/limit_compare.sv ***
`timescale 1ns/1ps
module limit_compare (
  input  wire logic clock,  // monitor clock
  input  wire logic rst,    // async reset
  input  wire logic ce,     // clock enable
  limit_if.cmp      lim     // channel comparison bundle
);
  import temp_limit_pkg::*;

  // ==========================================
  // hysteresis comparison
  function automatic logic hystNext(input logic cur, input temp_t t, input temp_t lim,
                                    input logic [3:0] h);
    logic [8:0] low;
    low = {1'b0, lim} - {5'h00, h};
    if (t > lim) return 1'b1;
    // a limit below the hysteresis never clears: nothing is below zero
    if (!low[8] && ({1'b0, t} < low)) return 1'b0;
    return cur;
  endfunction

  logic tripLive_r;
  logic highLive_r;
  logic tripNxt;
  logic highNxt;

  always_comb begin
    tripNxt = hystNext(tripLive_r, lim.tripTemp, lim.tripLimit, lim.hyst);
    highNxt = hystNext(highLive_r, lim.highTemp, lim.highLimit, lim.hyst);
  end

  // re-evaluated only on a fresh sample
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tripLive_r <= 1'b0;
      highLive_r <= 1'b0;
    end else if (ce && lim.sample) begin
      tripLive_r <= tripNxt;
      highLive_r <= highNxt;
    end
  end

  assign lim.tripLive = tripLive_r;
  assign lim.highLive = highLive_r;
  assign lim.tripRise = ce && lim.sample && tripNxt && !tripLive_r;
  assign lim.tripFall = ce && lim.sample && !tripNxt && tripLive_r;
  assign lim.highRise = ce && lim.sample && highNxt && !highLive_r;
  assign lim.highFall = ce && lim.sample && !highNxt && highLive_r;
endmodule

// *** rtl/limit_if.sv ***
`timescale 1ns/1ps
// carries one channel's comparison inputs and its results
interface limit_if;
  import temp_limit_pkg::*;
  logic  sample;
  temp_t tripTemp;
  temp_t highTemp;
  temp_t tripLimit;
  temp_t highLimit;
  logic [3:0] hyst;
  logic  tripLive;
  logic  highLive;
  logic  tripRise;
  logic  tripFall;
  logic  highRise;
  logic  highFall;
  modport ctl (output sample, tripTemp, highTemp, tripLimit, highLimit, hyst,
               input tripLive, highLive, tripRise, tripFall, highRise, highFall);
  modport cmp (input sample, tripTemp, highTemp, tripLimit, highLimit, hyst,
               output tripLive, highLive, tripRise, tripFall, highRise, highFall);
endinterface

// *** rtl/temp_limit_monitor.sv ***
// Overview of operation
// - channel-two trip live bit sets above trip limit, clears below limit minus hysteresis.
// - channel-one trip live bit sets above trip limit, clears below limit minus hysteresis.
// - channel-two high live bit sets above high limit, clears below limit minus hysteresis.
// - channel-one high live bit sets above high limit, clears below limit minus hysteresis.
// - trip beep enables, bits 6 and 5, drive beep when channel exceeds trip.
// - high beep enables, bits 2 and 1, drive beep when channel exceeds high.
// - bits 5-4 pick channel-one trip comparison source among four temperatures.
// - bits 1-0 pick channel-one high comparison source, same encoding.
// - trip enable bit 2 arms channel-two trip output, reset zero.
// - trip enable bit 1 arms channel-one trip output, reset one.
// - sensor kind bits 2 and 1 choose thermistor or transistor, reset one.
// - four-bit hysteresis per channel, reset 4, at bits 7-4 and 3-0.
// - thermal bus error bit 5 sets on client codes 0080 or 0081.
// - two-wire error bit 4 sets on missing acknowledge or timeout.
// - diode fault bits 2 and 1 show open or shorted diode.
// - latched bits set on both crossings; writing one clears, zero ignored.
// - wake enables drive wake event output when a limit is exceeded.
`timescale 1ns/1ps
module temp_limit_monitor
  import temp_limit_pkg::*;
(
  input  wire logic        clock,          // 40 MHz monitor clock
  input  wire logic        rst,            // async reset, active high
  input  wire logic        ce,             // clock enable, freezes state when low
  input  wire logic [7:0]  addr,           // register address
  input  wire logic [7:0]  wrData,         // write data
  input  wire logic        wrStb,          // write strobe
  input  wire logic        rdStb,          // read strobe
  output logic      [7:0]  rdData,         // read data, cycle after rdStb
  input  wire logic        ch1Sample,      // new channel-one samples valid
  input  wire logic        ch2Sample,      // new channel-two sample valid
  input  wire temp_limit_pkg::temp_t ch1Diode,    // channel-one diode temperature
  input  wire temp_limit_pkg::temp_t busTemp,     // thermal bus temperature
  input  wire temp_limit_pkg::temp_t twCpuTemp,   // two-wire processor temperature
  input  wire temp_limit_pkg::temp_t twMaxTemp,   // two-wire maximum temperature
  input  wire temp_limit_pkg::temp_t ch2Temp,     // channel-two temperature
  input  wire temp_limit_pkg::temp_t ch1TripLimit,// channel-one trip limit
  input  wire temp_limit_pkg::temp_t ch1HighLimit,// channel-one high limit
  input  wire temp_limit_pkg::temp_t ch2TripLimit,// channel-two trip limit
  input  wire temp_limit_pkg::temp_t ch2HighLimit,// channel-two high limit
  input  wire logic        busEnabled,     // thermal bus interface enabled
  input  wire logic        busDone,        // thermal bus answer pulse
  input  wire logic [15:0] busCode,        // thermal bus completion code
  input  wire logic        twEnabled,      // two-wire interface enabled
  input  wire logic        twNoAck,        // two-wire missing acknowledge pulse
  input  wire logic        twTimeout,      // two-wire timeout pulse
  input  wire logic        ch1DiodeBad,    // channel-one diode open or short
  input  wire logic        ch2DiodeBad,    // channel-two diode open or short
  output logic             ch1SensorKind,  // 1 transistor, 0 thermistor
  output logic             ch2SensorKind,  // 1 transistor, 0 thermistor
  output logic             overTempTrip,   // over-temperature trip output
  output logic             beep,           // beep request
  output logic             wakeEventOut,   // power-management wake event
  output logic             irq             // level interrupt
);
  import temp_limit_pkg::*;

  // ==========================================
  // register decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic wrLatched;
  logic wrBeep;
  logic wrSrc;
  logic wrTripEn;
  logic wrKind;
  logic wrHyst1;
  logic wrHyst2;
  logic wrWake;
  logic wrMask;

  always_comb begin
    wrLatched = ce && wrStb && hit(addr, OFF_LATCHED);
    wrBeep    = ce && wrStb && hit(addr, OFF_BEEP);
    wrSrc     = ce && wrStb && hit(addr, OFF_SRCSEL);
    wrTripEn  = ce && wrStb && hit(addr, OFF_TRIPEN);
    wrKind    = ce && wrStb && hit(addr, OFF_KIND);
    wrHyst1   = ce && wrStb && hit(addr, OFF_HYST1);
    wrHyst2   = ce && wrStb && hit(addr, OFF_HYST2);
    wrWake    = ce && wrStb && hit(addr, OFF_WAKEEN);
    wrMask    = ce && wrStb && hit(addr, OFF_IRQMASK);
  end

  // ==========================================
  // configuration registers
  logic [7:0] beepEn_r;
  logic [7:0] srcSel_r;
  logic [7:0] tripEn_r;
  logic [7:0] kind_r;
  logic [3:0] hyst1_r;
  logic [3:0] hyst2_r;
  logic [7:0] wakeEn_r;
  logic [7:0] irqMask_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) beepEn_r <= ZERO8;
    else if (wrBeep) beepEn_r <= wrData & EVT_MASK;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) srcSel_r <= ZERO8;
    else if (wrSrc) srcSel_r <= wrData & SRC_MASK;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) tripEn_r <= TRIPEN_RST;
    else if (wrTripEn) tripEn_r <= wrData & TRIPEN_MASK;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) kind_r <= KIND_RST;
    else if (wrKind) kind_r <= wrData & TRIPEN_MASK;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hyst1_r <= HYST_RST;
      hyst2_r <= HYST_RST;
    end else begin
      if (wrHyst1) hyst1_r <= wrData[HYST1_LSB +: 4];
      if (wrHyst2) hyst2_r <= wrData[HYST2_LSB +: 4];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) wakeEn_r <= ZERO8;
    else if (wrWake) wakeEn_r <= wrData & EVT_MASK;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) irqMask_r <= ZERO8;
    else if (wrMask) irqMask_r <= wrData & EVT_MASK;
  end

  assign ch1SensorKind = kind_r[BIT_CH1_HIGH];
  assign ch2SensorKind = kind_r[BIT_CH2_HIGH];

  // ==========================================
  // source selection and comparators
  function automatic temp_t pickSource(input logic [1:0] sel);
    source_e s;
    s = source_e'(sel);
    unique case (s)
      SRC_DIODE:  return ch1Diode;
      SRC_BUS:    return busTemp;
      SRC_TW_CPU: return twCpuTemp;
      SRC_TW_MAX: return twMaxTemp;
    endcase
  endfunction

  limit_if ch1 ();
  limit_if ch2 ();

  assign ch1.tripTemp  = pickSource(srcSel_r[TRIP_SRC_LSB +: 2]);
  assign ch1.highTemp  = pickSource(srcSel_r[HIGH_SRC_LSB +: 2]);
  assign ch1.sample    = ch1Sample;
  assign ch1.tripLimit = ch1TripLimit;
  assign ch1.highLimit = ch1HighLimit;
  assign ch1.hyst      = hyst1_r;
  assign ch2.sample    = ch2Sample;
  assign ch2.tripTemp  = ch2Temp;
  assign ch2.highTemp  = ch2Temp;
  assign ch2.tripLimit = ch2TripLimit;
  assign ch2.highLimit = ch2HighLimit;
  assign ch2.hyst      = hyst2_r;

  limit_compare u_cmp1 (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .lim   (ch1)
  );

  limit_compare u_cmp2 (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .lim   (ch2)
  );

  // ==========================================
  // live and latched status
  logic [7:0] live;
  logic [7:0] events;

  always_comb begin
    live = ZERO8;
    live[BIT_CH2_TRIP] = ch2.tripLive;
    live[BIT_CH1_TRIP] = ch1.tripLive;
    live[BIT_CH2_HIGH] = ch2.highLive;
    live[BIT_CH1_HIGH] = ch1.highLive;
    events = ZERO8;
    events[BIT_CH2_TRIP] = ch2.tripRise | ch2.tripFall;
    events[BIT_CH1_TRIP] = ch1.tripRise | ch1.tripFall;
    events[BIT_CH2_HIGH] = ch2.highRise | ch2.highFall;
    events[BIT_CH1_HIGH] = ch1.highRise | ch1.highFall;
  end

  logic [7:0] latched_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) latched_r <= ZERO8;
    else if (ce) latched_r <= ((latched_r & ~(wrLatched ? wrData : ZERO8)) | events) & EVT_MASK;
  end

  // ==========================================
  // fault status
  logic busErr_r;
  logic twErr_r;
  logic [1:0] diode_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) busErr_r <= 1'b0;
    else if (ce && busEnabled && busDone) busErr_r <= (busCode == BUS_ERR_A) || (busCode == BUS_ERR_B);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) twErr_r <= 1'b0;
    else if (ce && twEnabled && (twNoAck || twTimeout)) twErr_r <= 1'b1;
    else if (ce && !twEnabled) twErr_r <= 1'b0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) diode_r <= 2'h0;
    else if (ce) diode_r <= {ch2DiodeBad, ch1DiodeBad};
  end

  // ==========================================
  // outputs
  // beep on exceed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) beep <= 1'b0;
    else if (ce) beep <= |(live & beepEn_r);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) overTempTrip <= 1'b0;
    else if (ce) overTempTrip <= (ch1.tripLive && tripEn_r[BIT_CH1_HIGH])
                              || (ch2.tripLive && tripEn_r[BIT_CH2_HIGH]);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) wakeEventOut <= 1'b0;
    else if (ce) wakeEventOut <= |(live & wakeEn_r);
  end

  assign irq = |(latched_r & irqMask_r);

  // ==========================================
  // read port
  logic [7:0] rdNxt;

  always_comb begin
    unique case (addr)
      OFF_LATCHED: rdNxt = latched_r;
      OFF_LIVE:    rdNxt = live;
      OFF_BEEP:    rdNxt = beepEn_r;
      OFF_SRCSEL:  rdNxt = srcSel_r;
      OFF_TRIPEN:  rdNxt = tripEn_r;
      OFF_KIND:    rdNxt = kind_r;
      OFF_HYST1:   rdNxt = {hyst1_r, 4'h0};
      OFF_HYST2:   rdNxt = {4'h0, hyst2_r};
      OFF_FAULT:   rdNxt = {2'h0, busErr_r, twErr_r, 1'b0, diode_r, 1'b0};
      OFF_WAKEEN:  rdNxt = wakeEn_r;
      OFF_IRQMASK: rdNxt = irqMask_r;
      default:     rdNxt = ZERO8;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) rdData <= ZERO8;
    else if (ce) rdData <= rdStb ? rdNxt : ZERO8;
  end

  // ==========================================
  // checks
  // write-one clears unless event
  property p_w1c;
    @(posedge clock) disable iff (rst)
      (ce && wrLatched && wrData[BIT_CH1_TRIP] && !events[BIT_CH1_TRIP]) |=> !latched_r[BIT_CH1_TRIP];
  endproperty
  a_w1c: assert property (p_w1c) else $error("latched bit not cleared");

  property p_setwins;
    @(posedge clock) disable iff (rst)
      (ce && events[BIT_CH2_HIGH]) |=> latched_r[BIT_CH2_HIGH];
  endproperty
  a_setwins: assert property (p_setwins) else $error("event lost");

  property p_trip_out;
    @(posedge clock) disable iff (rst)
      (ce && ch1.tripLive && tripEn_r[BIT_CH1_HIGH]) |=> overTempTrip;
  endproperty
  a_trip_out: assert property (p_trip_out) else $error("trip output missing");

  property p_trip2_off;
    @(posedge clock) disable iff (rst)
      (ce && !ch1.tripLive && !tripEn_r[BIT_CH2_HIGH]) |=> !overTempTrip;
  endproperty
  a_trip2_off: assert property (p_trip2_off) else $error("disabled trip asserted");

  property p_beep;
    @(posedge clock) disable iff (rst)
      (ce && ch2.tripLive && beepEn_r[BIT_CH2_TRIP]) |=> beep;
  endproperty
  a_beep: assert property (p_beep) else $error("beep missing");

  property p_beep_high;
    @(posedge clock) disable iff (rst)
      (ce && ch1.highLive && beepEn_r[BIT_CH1_HIGH]) |=> beep;
  endproperty
  a_beep_high: assert property (p_beep_high) else $error("high beep missing");

  property p_wake;
    @(posedge clock) disable iff (rst)
      (ce && (live & wakeEn_r) == ZERO8) |=> !wakeEventOut;
  endproperty
  a_wake: assert property (p_wake) else $error("spurious wake");

  sequence s_high_seen;
    ce && ch2.sample && ch2Temp > ch2HighLimit;
  endsequence
  property p_ch2_high;
    @(posedge clock) disable iff (rst) s_high_seen |=> ch2.highLive;
  endproperty
  a_ch2_high: assert property (p_ch2_high) else $error("ch2 high not set");

  property p_bus_err;
    @(posedge clock) disable iff (rst)
      (ce && busEnabled && busDone && busCode == BUS_ERR_B) |=> busErr_r;
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus error not flagged");

  property p_rd_live;
    @(posedge clock) disable iff (rst)
      (ce && rdStb && addr == OFF_LIVE) |=> rdData == $past(live);
  endproperty
  a_rd_live: assert property (p_rd_live) else $error("live read wrong");
endmodule

// *** rtl/temp_limit_pkg.sv ***
package temp_limit_pkg;
  // ==========================================
  // register map
  localparam logic [7:0] OFF_LATCHED    = 8'h61;
  localparam logic [7:0] OFF_LIVE       = 8'h62;
  localparam logic [7:0] OFF_BEEP       = 8'h63;
  localparam logic [7:0] OFF_SRCSEL     = 8'h64;
  localparam logic [7:0] OFF_TRIPEN     = 8'h66;
  localparam logic [7:0] OFF_KIND       = 8'h6B;
  localparam logic [7:0] OFF_HYST1      = 8'h6C;
  localparam logic [7:0] OFF_HYST2      = 8'h6D;
  localparam logic [7:0] OFF_FAULT      = 8'h6F;
  localparam logic [7:0] OFF_WAKEEN     = 8'h60;
  localparam logic [7:0] OFF_IRQMASK    = 8'h68;
  // ==========================================
  // field positions
  localparam int BIT_CH2_TRIP = 6;
  localparam int BIT_CH1_TRIP = 5;
  localparam int BIT_CH2_HIGH = 2;
  localparam int BIT_CH1_HIGH = 1;
  localparam int BIT_BUS_ERR  = 5;
  localparam int BIT_TW_ERR   = 4;
  localparam int TRIP_SRC_LSB = 4;
  localparam int HIGH_SRC_LSB = 0;
  localparam int HYST1_LSB    = 4;
  localparam int HYST2_LSB    = 0;
  // ==========================================
  // masks of implemented bits and reset values
  localparam logic [7:0] EVT_MASK     = 8'h66;
  localparam logic [7:0] SRC_MASK     = 8'h33;
  localparam logic [7:0] TRIPEN_MASK  = 8'h06;
  localparam logic [7:0] FAULT_MASK   = 8'h36;
  localparam logic [7:0] TRIPEN_RST   = 8'h02;
  localparam logic [7:0] KIND_RST     = 8'h06;
  localparam logic [3:0] HYST_RST     = 4'h4;
  localparam logic [7:0] ZERO8        = 8'h00;
  // ==========================================
  // error codes from the thermal bus client
  localparam logic [15:0] BUS_ERR_A   = 16'h0080;
  localparam logic [15:0] BUS_ERR_B   = 16'h0081;
  // ==========================================
  // source selection for the channel-one comparisons
  typedef enum logic [1:0] {
    SRC_DIODE  = 2'h0,
    SRC_BUS    = 2'h1,
    SRC_TW_CPU = 2'h2,
    SRC_TW_MAX = 2'h3
  } source_e;
  typedef logic [7:0] temp_t;
endpackage

// *** verification/sensor_side_model.sv ***
`timescale 1ns/1ps
// ==========================================
// far side: diode, thermal bus and two-wire sources
module sensor_side_model (
  input  wire logic                   clock,        // monitor clock
  output logic                        ch1Sample,    // channel-one sample strobe
  output logic                        ch2Sample,    // channel-two sample strobe
  output temp_limit_pkg::temp_t       ch1Diode,     // diode reading
  output temp_limit_pkg::temp_t       busTemp,      // thermal bus reading
  output temp_limit_pkg::temp_t       twCpuTemp,    // two-wire processor reading
  output temp_limit_pkg::temp_t       twMaxTemp,    // two-wire maximum reading
  output temp_limit_pkg::temp_t       ch2Temp,      // channel-two reading
  output logic                        busDone,      // thermal bus answer pulse
  output logic                 [15:0] busCode,      // completion code
  output logic                        twNoAck,      // missing acknowledge pulse
  output logic                        twTimeout,    // timeout pulse
  output logic                        ch1DiodeBad,  // diode one open or short
  output logic                        ch2DiodeBad   // diode two open or short
);
  import temp_limit_pkg::*;
  initial begin
    {ch1Sample, ch2Sample, busDone, twNoAck, twTimeout, ch1DiodeBad, ch2DiodeBad} = 7'h00;
    {ch1Diode, busTemp, twCpuTemp, twMaxTemp, ch2Temp} = 40'h0;
    busCode = 16'hFFFF;
  end
  task automatic sample1(input temp_t d, input temp_t b, input temp_t c, input temp_t m);
    @(posedge clock);
    ch1Diode  <= d;
    busTemp   <= b;
    twCpuTemp <= c;
    twMaxTemp <= m;
    ch1Sample <= 1'b1;
    @(posedge clock);
    ch1Sample <= 1'b0;
  endtask
  task automatic sample2(input temp_t t);
    @(posedge clock);
    ch2Temp   <= t;
    ch2Sample <= 1'b1;
    @(posedge clock);
    ch2Sample <= 1'b0;
  endtask
  task automatic busAnswer(input logic [15:0] code);
    @(posedge clock);
    busCode <= code;
    busDone <= 1'b1;
    @(posedge clock);
    busDone <= 1'b0;
    // code lines are meaningless between answers, so never hold the last one
    busCode <= ~code;
  endtask
  task automatic twFault(input logic timeout);
    @(posedge clock);
    twNoAck   <= ~timeout;
    twTimeout <= timeout;
    @(posedge clock);
    twNoAck   <= 1'b0;
    twTimeout <= 1'b0;
  endtask
  task automatic setDiode(input logic b1, input logic b2);
    @(posedge clock);
    ch1DiodeBad <= b1;
    ch2DiodeBad <= b2;
  endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import temp_limit_pkg::*;
  logic clock = 1'b0, rst = 1'b1, ce = 1'b1, wrStb = 1'b0, rdStb = 1'b0;
  logic busEnabled = 1'b0, twEnabled = 1'b0;
  logic [7:0] addr = 8'h00, wrData = 8'h00, rd;
  wire logic [7:0] rdData;
  wire logic ch1Sample, ch2Sample, busDone, twNoAck, twTimeout, ch1DiodeBad, ch2DiodeBad;
  wire logic ch1SensorKind, ch2SensorKind, overTempTrip, beep, wakeEventOut, irq;
  wire logic [15:0] busCode;
  wire temp_t ch1Diode, busTemp, twCpuTemp, twMaxTemp, ch2Temp;
  wire logic [7:0] outs = {2'h0, ch1SensorKind, ch2SensorKind, overTempTrip, beep, wakeEventOut, irq};
  int numErrors = 0, nChecks = 0;
  temp_t ch1TripLimit = 8'h64, ch1HighLimit = 8'h5A, ch2TripLimit = 8'h64, ch2HighLimit = 8'h50;
  logic [7:0] tAddr [12] = '{8'h61, 8'h62, 8'h63, 8'h64, 8'h66, 8'h6B, 8'h6C, 8'h6D, 8'h6F, 8'h60, 8'h68, 8'h70};
  logic [7:0] tRst  [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h06, 8'h40, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] tOnes [12] = '{8'h00, 8'h00, 8'h66, 8'h33, 8'h06, 8'h06, 8'hF0, 8'h0F, 8'h00, 8'h66, 8'h66, 8'h00};
  // channel-two walk through the hysteresis band: reading, live bits, outputs
  logic [7:0] wTemp [5] = '{8'h65, 8'h63, 8'h61, 8'h4F, 8'h4D};
  logic [7:0] wLive [5] = '{8'h44, 8'h44, 8'h04, 8'h04, 8'h00};
  logic [7:0] wOuts [5] = '{8'h36, 8'h36, 8'h32, 8'h32, 8'h30};

  initial begin
    forever #12.5 clock = ~clock;
  end

  temp_limit_monitor temp_limit_monitor_i (
    .clock(clock), .rst(rst), .ce(ce), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .ch1Sample(ch1Sample), .ch2Sample(ch2Sample), .ch1Diode(ch1Diode),
    .busTemp(busTemp), .twCpuTemp(twCpuTemp), .twMaxTemp(twMaxTemp), .ch2Temp(ch2Temp),
    .ch1TripLimit(ch1TripLimit), .ch1HighLimit(ch1HighLimit), .ch2TripLimit(ch2TripLimit),
    .ch2HighLimit(ch2HighLimit),
    .busEnabled(busEnabled), .busDone(busDone), .busCode(busCode), .twEnabled(twEnabled),
    .twNoAck(twNoAck), .twTimeout(twTimeout), .ch1DiodeBad(ch1DiodeBad), .ch2DiodeBad(ch2DiodeBad),
    .ch1SensorKind(ch1SensorKind), .ch2SensorKind(ch2SensorKind), .overTempTrip(overTempTrip),
    .beep(beep), .wakeEventOut(wakeEventOut), .irq(irq)
  );

  sensor_side_model sensor_side_model_i (
    .clock(clock), .ch1Sample(ch1Sample), .ch2Sample(ch2Sample), .ch1Diode(ch1Diode),
    .busTemp(busTemp), .twCpuTemp(twCpuTemp), .twMaxTemp(twMaxTemp), .ch2Temp(ch2Temp),
    .busDone(busDone), .busCode(busCode), .twNoAck(twNoAck), .twTimeout(twTimeout),
    .ch1DiodeBad(ch1DiodeBad), .ch2DiodeBad(ch2DiodeBad)
  );

  // ==========================================
  // access and compare tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clock);
    wrStb  <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1 rd = rdData;
    chk(rd, exp);
  endtask
  // outputs follow one edge after the sampling edge
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask
  function automatic temp_t pick(input int i, input int s);
    if (i == s) return 8'h78;
    if (i == 3 - s) return 8'h5F;
    return 8'h00;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(outs, 8'h30);
    for (int i = 0; i < 12; i++) begin
      rdChk(tAddr[i], tRst[i]);
      wr(tAddr[i], 8'hFF);
      rdChk(tAddr[i], tOnes[i]);
    end
    $display("test registers done");
    wr(OFF_KIND, 8'h02);
    settle();
    chk(outs, 8'h20);
    wr(OFF_KIND, 8'h04);
    settle();
    chk(outs, 8'h10);
    wr(OFF_KIND, 8'h06);
    $display("test sensor kind done");
    wr(OFF_TRIPEN, 8'h02);
    wr(OFF_BEEP, 8'h02);
    wr(OFF_WAKEEN, 8'h00);
    wr(OFF_IRQMASK, 8'h00);
    wr(OFF_HYST1, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_SRCSEL, {2'h0, s[1:0], 2'h0, 2'(3 - s)});
      sensor_side_model_i.sample1(pick(0, s), pick(1, s), pick(2, s), pick(3, s));
      settle();
      rdChk(OFF_LIVE, 8'h22);
      chk(outs, 8'h3C);
      sensor_side_model_i.sample1(8'h00, 8'h00, 8'h00, 8'h00);
      settle();
      rdChk(OFF_LIVE, 8'h00);
      chk(outs, 8'h30);
    end
    // limits are live inputs: a higher trip limit keeps the trip bit clear
    @(posedge clock);
    ch1TripLimit <= 8'h7A;
    ch1HighLimit <= 8'h77;
    sensor_side_model_i.sample1(8'h78, 8'h00, 8'h00, 8'h79);
    settle();
    rdChk(OFF_LIVE, 8'h02);
    sensor_side_model_i.sample1(8'h00, 8'h00, 8'h00, 8'h00);
    rdChk(OFF_LATCHED, 8'h22);
    wr(OFF_LATCHED, 8'hFF);
    rdChk(OFF_LATCHED, 8'h00);
    $display("test channel one done");
    wr(OFF_HYST2, 8'h02);
    wr(OFF_BEEP, 8'h40);
    wr(OFF_WAKEEN, 8'h04);
    for (int i = 0; i < 5; i++) begin
      sensor_side_model_i.sample2(wTemp[i]);
      settle();
      rdChk(OFF_LIVE, wLive[i]);
      chk(outs, wOuts[i]);
    end
    rdChk(OFF_LATCHED, 8'h44);
    wr(OFF_LATCHED, 8'h00);
    rdChk(OFF_LATCHED, 8'h44);
    wr(OFF_LATCHED, 8'h04);
    rdChk(OFF_LATCHED, 8'h40);
    wr(OFF_IRQMASK, 8'h40);
    settle();
    chk(outs, 8'h31);
    wr(OFF_LATCHED, 8'h40);
    settle();
    chk(outs, 8'h30);
    wr(OFF_TRIPEN, 8'h04);
    sensor_side_model_i.sample2(8'h65);
    settle();
    chk(outs, 8'h3F);
    wr(OFF_LIVE, 8'h00);
    rdChk(OFF_LIVE, 8'h44);
    // clock enable low: a write and a sample must both be lost
    @(posedge clock);
    ce <= 1'b0;
    wr(OFF_HYST2, 8'h0F);
    sensor_side_model_i.sample2(8'h00);
    @(posedge clock);
    ce <= 1'b1;
    rdChk(OFF_HYST2, 8'h02);
    rdChk(OFF_LIVE, 8'h44);
    @(posedge clock);
    ch2TripLimit <= 8'h70;
    ch2HighLimit <= 8'h68;
    sensor_side_model_i.sample2(8'h65);
    settle();
    rdChk(OFF_LIVE, 8'h00);
    $display("test channel two done");
    @(posedge clock);
    busEnabled <= 1'b1;
    twEnabled  <= 1'b1;
    sensor_side_model_i.busAnswer(16'h0080);
    settle();
    rdChk(OFF_FAULT, 8'h20);
    sensor_side_model_i.busAnswer(16'h0001);
    settle();
    rdChk(OFF_FAULT, 8'h00);
    sensor_side_model_i.busAnswer(16'h0081);
    sensor_side_model_i.twFault(1'b0);
    settle();
    rdChk(OFF_FAULT, 8'h30);
    @(posedge clock);
    twEnabled <= 1'b0;
    settle();
    rdChk(OFF_FAULT, 8'h20);
    @(posedge clock);
    twEnabled <= 1'b1;
    sensor_side_model_i.twFault(1'b1);
    sensor_side_model_i.setDiode(1'b1, 1'b0);
    settle();
    rdChk(OFF_FAULT, 8'h32);
    sensor_side_model_i.setDiode(1'b0, 1'b1);
    settle();
    rdChk(OFF_FAULT, 8'h34);
    $display("test faults done");
    // reset in mid-run: irq and the trip enables go back to their reset state
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(outs, 8'h30);
    rdChk(OFF_TRIPEN, 8'h02);
    $display("test reset done");
    final_report();
  end

  // a hang cuts the run short as a mismatch
  initial begin
    repeat (100000) @(posedge clock);
    numErrors++;
    $display("BAD t=%0t run limit reached", $time);
    final_report();
  end
endmodule
